// File: bench/hrrs_ctrl_model.sv
// Memory controller stand-in driving command pins and data lanes
`timescale 1ns/100ps
module hrrs_ctrl_model
   import hrrs_pkg::*;
(
   input  wire logic   clk,
   output logic        ck,
   output logic        cs_n,
   output logic        act_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [1:0]  bg,
   output logic [1:0]  ba,
   output logic [17:0] addr,
   output logic [15:0] dq
);
   localparam logic [4:0] MRS = {2'b01, CMD_MRS};

   initial begin
      ck = 1'b0;
      {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
      bg = 2'h0;
      ba = 2'h0;
      addr = 18'h3FFFF;
      dq = 16'hFFFF;
   end

   // Pins move on a core edge; ck rises mid-slot for wide setup and hold
   // Link clock stands still between slots
   task automatic cmd(input logic [4:0] c, input logic [1:0] g,
                      input logic [1:0] b, input logic [17:0] a,
                      input logic [15:0] d);
      @(posedge clk);
      {cs_n, act_n, ras_n, cas_n, we_n} <= c;
      bg <= g;
      ba <= b;
      // Deselected address is not held
      addr <= c[4] ? ~addr : a;
      dq <= d;
      #62.5 ck = 1'b1;
      #62.5 ck = 1'b0;
   endtask : cmd

   task automatic enter();
      cmd({2'b01, CMD_PRE}, 2'h0, 2'h0, 18'h00400, 16'hFFFF);
      cmd(MRS, 2'h1, 2'h0, 18'h02000, 16'hFFFF);
   endtask : enter

   // Step bad gets a wrong A7; bad of 4 leaves the key intact
   task automatic key(input int bad);
      logic [4:0] k;
      for (int i = 0; i < 4; i++) begin
         k = GUARD_KEY[i] ^ ((i == bad) ? 5'h01 : 5'h00);
         cmd(MRS, 2'h2, 2'h0, {6'h0, k, KEY_LOW_ONES}, 16'hFFFF);
      end
   endtask : key

   task automatic leave();
      cmd({2'b01, CMD_PRE}, 2'h0, 2'h0, 18'h00400, 16'hFFFF);
      cmd(MRS, 2'h1, 2'h0, 18'h00000, 16'hFFFF);
   endtask : leave
endmodule : hrrs_ctrl_model

// File: bench/hrrs_top_bench.sv
// Self-checking bench for the permanent row repair sequencer
`timescale 1ns/100ps
module hrrs_top_bench
   import hrrs_pkg::*;
();
   localparam int          WL_CK = 2;
   localparam logic [17:0] ROW_A = 18'h1C2A5;
   localparam logic [17:0] ROW_B = 18'h1C35A;
   logic        CORE_CLK = 1'b0;
   logic        NRST = 1'b0;
   logic [2:0]  AVS_ADDRESS = 3'h0;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST, CK, CS_N, ACT_N, RAS_N, CAS_N, WE_N;
   logic [1:0]  BG, BA, FUSE_VALID;
   logic [17:0] ADDR;
   logic [15:0] DQ;
   logic        REPAIR_BUSY, REF_STROBE;
   logic [7:0]  REF_SKIP_MASK;
   logic [7:0]  ref_mask = 8'h0;
   logic [35:0] FUSE_ROW;
   int          n_fail = 0;
   int          compares = 0;

   always #2 CORE_CLK = ~CORE_CLK;

   hrrs_top #(.PROG_CYCLES(200), .SETTLE_CYCLES(20)) uut (.*);

   hrrs_ctrl_model u_ctrl (.clk(CORE_CLK), .ck(CK), .cs_n(CS_N),
      .act_n(ACT_N), .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N),
      .bg(BG), .ba(BA), .addr(ADDR), .dq(DQ));

   // Strobe lasts one cycle, so catch it here
   always @(posedge CORE_CLK) begin
      if (REF_STROBE === 1'b1)
         ref_mask <= REF_SKIP_MASK;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= ~w;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (n >= 100)
         n_fail++;
   endtask : bus

   task automatic rd(input logic [2:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(64'(q), 64'(exp));
   endtask : rd

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   // One full repair attempt; prog says a fuse should be programmed
   task automatic flow(input logic [1:0] g, input logic [1:0] b,
                       input logic [17:0] row, input logic ap,
                       input logic [15:0] d, input int bad, input bit prog);
      int n;
      u_ctrl.enter();
      u_ctrl.key(bad);
      u_ctrl.cmd({2'b00, row[16:14]}, g, b, row, 16'hFFFF);
      u_ctrl.cmd({2'b01, CMD_WR}, ~g, ~b, {7'h0, ap, 10'h2A8}, 16'hFFFF);
      for (int k = 1; k <= WL_CK + 4; k++)
         u_ctrl.cmd(5'h1F, g, b, row,
            (k >= WL_CK && k < WL_CK + 4) ? d : 16'hFFFF);
      if (prog)
         chk(64'(REPAIR_BUSY), 64'h1);
      // Refresh only in the auto-precharge flow
      if (ap && prog) begin
         u_ctrl.cmd({2'b01, CMD_REF}, 2'h0, 2'h0, 18'h0, 16'hFFFF);
         chk(64'(ref_mask), 64'(8'h3 << {g[0], b[1], 1'b0}));
      end
      repeat (260) @(posedge CORE_CLK);
      u_ctrl.leave();
      if (prog)
         chk(64'(REPAIR_BUSY), 64'h1);
      n = 0;
      while (REPAIR_BUSY !== 1'b0 && n < 1000) begin
         @(posedge CORE_CLK);
         n++;
      end
      chk(64'(REPAIR_BUSY), 64'h0);
      u_ctrl.cmd({2'b01, CMD_MRS}, 2'h0, 2'h0, 18'h00A30, 16'hFFFF);
   endtask : flow

   task automatic t_regs();
      rd(REG_WL_IDX, 32'h10);
      rd(REG_SUPPORT_IDX, 32'hC0);
      rd(REG_STATUS_IDX, 32'h0);
      wr(REG_STATUS_IDX, 32'hFF);
      rd(REG_STATUS_IDX, 32'h0);
      wr(3'h6, 32'hFFFF);
      rd(3'h6, 32'h0);
      wr(REG_WL_IDX, 32'(WL_CK));
      rd(REG_WL_IDX, 32'(WL_CK));
      $display("test regs done");
   endtask : t_regs

   task automatic t_bad_key();
      for (int bad = 0; bad < 4; bad += 3) begin
         flow(2'h0, 2'h2, ROW_A, 1'b1, 16'h0, bad, 1'b0);
         chk(64'(FUSE_VALID), 64'h0);
         rd(REG_STATUS_IDX, 32'h0);
      end
      $display("test bad key done");
   endtask : t_bad_key

   task automatic t_wra();
      flow(2'h0, 2'h2, ROW_A, 1'b1, 16'h0, 4, 1'b1);
      chk(64'(FUSE_VALID), 64'h1);
      chk(64'(FUSE_ROW[17:0]), 64'(ROW_A));
      rd(REG_ROW0_IDX, 32'(ROW_A));
      rd(REG_STATUS_IDX, 32'h10);
      $display("test auto-precharge flow done");
   endtask : t_wra

   task automatic t_wr();
      flow(2'h1, 2'h1, ROW_B, 1'b0, 16'hFFFF, 4, 1'b0);
      chk(64'(FUSE_VALID), 64'h1);
      flow(2'h1, 2'h1, ROW_B, 1'b0, 16'h0, 4, 1'b1);
      chk(64'(FUSE_VALID), 64'h3);
      chk(64'(FUSE_ROW[35:18]), 64'(ROW_B));
      flow(2'h0, 2'h2, ROW_B, 1'b0, 16'h0, 4, 1'b0);
      chk(64'(FUSE_ROW[17:0]), 64'(ROW_A));
      rd(REG_ROW1_IDX, 32'(ROW_B));
      rd(REG_STATUS_IDX, 32'h30);
      $display("test plain write flow done");
   endtask : t_wr

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   initial begin
      repeat (12) @(posedge CORE_CLK);
      NRST <= 1'b1;
      t_regs();
      t_bad_key();
      t_wra();
      t_wr();
      finish_test();
   end

   // Whole run needs some 20 us
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule : hrrs_top_bench

// File: design/hrrs_pkg.sv
// Shared constants for the permanent row repair sequencer
package hrrs_pkg;
   // Core clock and repair timing, figures in their own units
   localparam int CORE_CLK_MHZ          = 250;
   localparam int REPAIR_PROGRAM_TIME_MS = 2000;
   localparam int REPAIR_EXIT_TIME_NS    = 15;
   localparam int REPAIR_SETTLE_TIME_US  = 50;
   // Least times, rounded up to whole core cycles
   localparam int REPAIR_PROGRAM_CYC =
      REPAIR_PROGRAM_TIME_MS * CORE_CLK_MHZ * 1000;
   localparam int REPAIR_EXIT_CYC =
      (REPAIR_EXIT_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int REPAIR_SETTLE_CYC = REPAIR_SETTLE_TIME_US * CORE_CLK_MHZ;

   // Register word indices; byte address is four times the index
   localparam logic [2:0] REG_WL_IDX      = 3'h0;
   localparam logic [2:0] REG_STATUS_IDX  = 3'h1;
   localparam logic [2:0] REG_SUPPORT_IDX = 3'h2;
   localparam logic [2:0] REG_ROW0_IDX    = 3'h3;
   localparam logic [2:0] REG_ROW1_IDX    = 3'h4;
   localparam logic [5:0] WL_RESET        = 6'h10;
   // Field positions
   localparam int STAT_MODE_BIT  = 0;
   localparam int STAT_BUSY_BIT  = 1;
   localparam int STAT_FUSE_LSB  = 4;
   localparam int SUP_HARD_BIT   = 7;
   localparam int SUP_SOFT_BIT   = 6;

   // Mode register selects {BG0, BA1, BA0}
   localparam logic [2:0] MR_KEY    = 3'h0;
   localparam logic [2:0] MR_REPAIR = 3'h4;
   localparam int MR4_HARD_BIT = 13;
   localparam int MR4_SOFT_BIT = 5;
   localparam int AP_BIT       = 10;
   // Guard key A11..A7, first step in element 0
   localparam logic [3:0][4:0] GUARD_KEY = {5'h07, 5'h17, 5'h0F, 5'h19};
   localparam logic [6:0] KEY_LOW_ONES = 7'h7F;
   localparam int DATA_BEATS = 4;
   localparam int NUM_BG     = 2;
   // Command codes {RAS_n, CAS_n, WE_n} with ACT_n high
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_WR  = 3'h4;

   typedef enum logic [3:0] {
      ST_IDLE, ST_KEY, ST_ARMED, ST_ROW, ST_LAT, ST_PROG,
      ST_PRE, ST_EXIT, ST_CLOSE, ST_SETTLE, ST_HOLD
   } hrrs_state_t;
endpackage : hrrs_pkg

// File: design/hrrs_sync.sv
// Two-stage synchroniser for pins from outside the core clock
`timescale 1ns/100ps
module hrrs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] out;
   } hrrs_sync_t;

   hrrs_sync_t s;
   hrrs_sync_t next_s;

   always_comb begin
      next_s.meta = d;
      next_s.out  = s.meta;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.out;
endmodule : hrrs_sync

// File: design/hrrs_top.sv
// Permanent row repair sequencer: guard key, repair flow, register slave
// Overview of operation
// - One permanent repair per bank group only
// - Programmed repair undone only by reset, which loads FUSE_INIT
// - Entry qualified only by four-step guard key
// - Key: MR0, BG/BA zero, fixed A11..A7
// - Low address bits all ones always accepted
// - Upper bank group bit ignored for x16
// - Broken key: no repair, never hangs
// - After broken entry, ACT/WR act normally
// - No error indication for bad key
// - Write column and bank are ignored
// - Four low beats repair, high cancels
// - Commands accepted only after settling time
// - Refresh keeps all but repaired bank pair, auto-precharge flow only
// - Support bits 7 and 6 reported
`timescale 1ns/100ps
module hrrs_top
   import hrrs_pkg::*;
#(
   parameter int          DQ_W          = 16,
   parameter bit          X16           = 1'b1,
   parameter bit          STRICT_LOW    = 1'b1,
   parameter bit          SOFT_SUPPORT  = 1'b1,
   parameter int          PROG_CYCLES   = REPAIR_PROGRAM_CYC,
   parameter int          SETTLE_CYCLES = REPAIR_SETTLE_CYC,
   parameter logic [1:0]  FUSE_INIT     = 2'h0
) (
   input  wire logic               CORE_CLK,
   input  wire logic               NRST,
   input  wire logic [2:0]         AVS_ADDRESS,
   input  wire logic               AVS_READ,
   input  wire logic               AVS_WRITE,
   input  wire logic [31:0]        AVS_WRITEDATA,
   output logic      [31:0]        AVS_READDATA,
   output logic                    AVS_WAITREQUEST,
   input  wire logic               CK,
   input  wire logic               CS_N,
   input  wire logic               ACT_N,
   input  wire logic               RAS_N,
   input  wire logic               CAS_N,
   input  wire logic               WE_N,
   input  wire logic [1:0]         BG,
   input  wire logic [1:0]         BA,
   input  wire logic [17:0]        ADDR,
   input  wire logic [DQ_W-1:0]    DQ,
   output logic                    REPAIR_BUSY,
   output logic                    REF_STROBE,
   output logic [NUM_BG*4-1:0]     REF_SKIP_MASK,
   output logic [NUM_BG-1:0]       FUSE_VALID,
   output logic [NUM_BG*18-1:0]    FUSE_ROW
);
   localparam int PIN_W = 28 + DQ_W;

   typedef struct packed {
      hrrs_state_t                 st;
      logic [1:0]                  step;
      logic                        hard;
      logic                        bg;
      logic [1:0]                  ba;
      logic [17:0]                 row;
      logic                        ap;
      logic [6:0]                  beat;
      logic                        all_low;
      logic                        bad;
      logic [31:0]                 tmr;
      logic [NUM_BG-1:0]           fused;
      logic [NUM_BG-1:0][17:0]     frow;
      logic                        ck_d;
      logic                        ack;
      logic [31:0]                 rdata;
      logic [5:0]                  wl;
      logic                        ref_stb;
      logic [NUM_BG*4-1:0]         ref_mask;
   } hrrs_core_t;

   hrrs_core_t s;
   hrrs_core_t next_s;

   logic [PIN_W-1:0] pin_q;
   logic             ck_s;
   logic             cs_n_s;
   logic             act_n_s;
   logic [2:0]       rcw_s;
   logic [1:0]       bg_s;
   logic [1:0]       ba_s;
   logic [17:0]      addr_s;
   logic [DQ_W-1:0]  dq_s;

   hrrs_sync #(
      .W (PIN_W)
   ) u_pin_sync (
      .clk  (CORE_CLK),
      .nrst (NRST),
      .d    ({CK, CS_N, ACT_N, RAS_N, CAS_N, WE_N, BG, BA, ADDR, DQ}),
      .q    (pin_q)
   );

   assign {ck_s, cs_n_s, act_n_s, rcw_s, bg_s, ba_s, addr_s, dq_s} = pin_q;

   // Command decode on the sampled rising edge of CK
   logic       ck_rise;
   logic       cmd_v;
   logic       is_act;
   logic       is_mrs;
   logic       is_ref;
   logic       is_pre;
   logic       is_wr;
   logic [2:0] mr_sel;
   logic       mr_bg_ok;
   logic       key_hit;
   logic       mr4_wr;
   logic       mr4_clear;
   logic       beat_v;
   logic [6:0] beat_nx;
   logic       last_beat;
   logic       low_now;

   always_comb begin
      ck_rise  = ck_s & ~s.ck_d;
      cmd_v    = ck_rise & ~cs_n_s;
      is_act   = cmd_v & ~act_n_s;
      is_mrs   = cmd_v & act_n_s & (rcw_s == CMD_MRS);
      is_ref   = cmd_v & act_n_s & (rcw_s == CMD_REF);
      is_pre   = cmd_v & act_n_s & (rcw_s == CMD_PRE);
      is_wr    = cmd_v & act_n_s & (rcw_s == CMD_WR);
      mr_sel   = {bg_s[0], ba_s};
      mr_bg_ok = X16 | ~bg_s[1];
      mr4_wr   = is_mrs & mr_bg_ok & (mr_sel == MR_REPAIR);
      mr4_clear = mr4_wr & ~addr_s[MR4_HARD_BIT] & ~addr_s[MR4_SOFT_BIT];
      // All-ones low bits always pass; strict mode demands them
      key_hit  = is_mrs & mr_bg_ok & (mr_sel == MR_KEY)
                 & (addr_s[11:7] == GUARD_KEY[s.step])
                 & (~STRICT_LOW | (addr_s[6:0] == KEY_LOW_ONES));
      beat_nx  = s.beat + 7'h01;
      beat_v   = ck_rise & (beat_nx >= {1'b0, s.wl});
      last_beat = beat_v
                  & (beat_nx - {1'b0, s.wl} == 7'(DATA_BEATS - 1));
      low_now  = (dq_s == '0);
   end

   always_comb begin
      next_s          = s;
      next_s.ck_d     = ck_s;
      next_s.ref_stb  = is_ref;
      next_s.ref_mask = '0;
      next_s.ack      = (AVS_READ | AVS_WRITE) & ~s.ack;

      // In the auto-precharge flow refresh runs; bank pair of the repair row is skipped
      if (is_ref && s.ap && (s.st inside {ST_PROG, ST_PRE, ST_EXIT,
                                          ST_CLOSE, ST_SETTLE})) begin
         next_s.ref_mask[{s.bg, s.ba[1], 1'b0}] = 1'b1;
         next_s.ref_mask[{s.bg, s.ba[1], 1'b1}] = 1'b1;
      end

      unique case (s.st)
         ST_IDLE: begin
            if (mr4_wr && (addr_s[MR4_HARD_BIT] || addr_s[MR4_SOFT_BIT]))
            begin
               next_s.st   = ST_KEY;
               next_s.step = 2'h0;
               next_s.hard = addr_s[MR4_HARD_BIT];
            end
         end
         ST_KEY: begin
            if (cmd_v) begin
               if (key_hit && s.step == 2'h3) begin
                  next_s.step = 2'h0;
                  // Volatile repair flow is not carried out here
                  next_s.st   = s.hard ? ST_ARMED : ST_HOLD;
               end else if (key_hit) begin
                  next_s.step = s.step + 2'h1;
               end else begin
                  // Silent drop to hold, no flag anywhere
                  next_s.step = 2'h0;
                  next_s.st   = ST_HOLD;
               end
            end
         end
         ST_ARMED: begin
            if (is_act) begin
               next_s.st  = ST_ROW;
               next_s.bg  = bg_s[0];
               next_s.ba  = ba_s;
               next_s.row = addr_s;
            end else if (cmd_v) begin
               next_s.st = ST_HOLD;
            end
         end
         ST_ROW: begin
            if (is_wr) begin
               // Column and bank of the write are not looked at
               next_s.st      = ST_LAT;
               next_s.ap      = addr_s[AP_BIT];
               next_s.beat    = 7'h00;
               next_s.all_low = 1'b1;
            end else if (cmd_v) begin
               next_s.st = ST_HOLD;
            end
         end
         ST_LAT: begin
            if (ck_rise) begin
               next_s.beat = beat_nx;
            end
            if (beat_v) begin
               next_s.all_low = s.all_low & low_now;
            end
            // Only four low beats program; high or mixed cancels
            if (last_beat) begin
               if (s.all_low && low_now && !s.fused[s.bg]) begin
                  next_s.st  = ST_PROG;
                  next_s.tmr = '0;
                  next_s.bad = 1'b0;
               end else begin
                  next_s.st = ST_HOLD;
               end
            end
         end
         ST_PROG: begin
            // Anything but refresh spoils it; plain flow allows none
            if (cmd_v && !(is_ref && s.ap)) begin
               next_s.bad = 1'b1;
            end
            next_s.tmr = s.tmr + 32'h1;
            if (s.tmr == 32'(PROG_CYCLES - 1)) begin
               next_s.st = ST_PRE;
               if (!s.bad && !(cmd_v && !(is_ref && s.ap))) begin
                  next_s.fused[s.bg] = 1'b1;
                  next_s.frow[s.bg]  = s.row;
               end
            end
         end
         ST_PRE: begin
            if (is_pre) begin
               next_s.st  = ST_EXIT;
               next_s.tmr = '0;
            end
         end
         ST_EXIT: begin
            next_s.tmr = s.tmr + 32'h1;
            if (s.tmr == 32'(REPAIR_EXIT_CYC - 1)) begin
               next_s.st = ST_CLOSE;
            end
         end
         ST_CLOSE: begin
            if (mr4_wr && !addr_s[MR4_HARD_BIT]) begin
               next_s.st  = ST_SETTLE;
               next_s.tmr = '0;
            end
         end
         ST_SETTLE: begin
            next_s.tmr = s.tmr + 32'h1;
            if (s.tmr == 32'(SETTLE_CYCLES - 1)) begin
               next_s.st = ST_IDLE;
               next_s.ap = 1'b0;
            end
         end
         ST_HOLD: begin
            // ACT and WR pass to the array untouched here
            if (mr4_clear) begin
               next_s.st = ST_IDLE;
               next_s.ap = 1'b0;
            end
         end
      endcase

      // Register slave, answered one cycle after the request
      // Write lands only on the edge that sees waitrequest low
      if (AVS_WRITE && s.ack && AVS_ADDRESS == REG_WL_IDX) begin
         next_s.wl = AVS_WRITEDATA[5:0];
      end
      if (AVS_READ && !s.ack) begin
         next_s.rdata = '0;
         unique case (AVS_ADDRESS)
            REG_WL_IDX: next_s.rdata[5:0] = s.wl;
            REG_STATUS_IDX: begin
               next_s.rdata[STAT_MODE_BIT] = (s.st != ST_IDLE);
               next_s.rdata[STAT_BUSY_BIT] = REPAIR_BUSY;
               next_s.rdata[STAT_FUSE_LSB +: NUM_BG] = s.fused;
            end
            REG_SUPPORT_IDX: begin
               next_s.rdata[SUP_HARD_BIT] = 1'b1;
               next_s.rdata[SUP_SOFT_BIT] = SOFT_SUPPORT;
            end
            REG_ROW0_IDX: next_s.rdata[17:0] = s.frow[0];
            REG_ROW1_IDX: next_s.rdata[17:0] = s.frow[1];
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         s       <= '0;
         s.st    <= ST_IDLE;
         s.wl    <= WL_RESET;
         s.fused <= FUSE_INIT;
      end else begin
         s <= next_s;
      end
   end

   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
   assign AVS_READDATA    = s.rdata;
   assign REPAIR_BUSY     = s.st inside {ST_PROG, ST_PRE, ST_EXIT,
                                         ST_CLOSE, ST_SETTLE};
   assign REF_STROBE      = s.ref_stb;
   assign REF_SKIP_MASK   = s.ref_mask;
   assign FUSE_VALID      = s.fused;
   assign FUSE_ROW        = s.frow;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);

   AST_KEY_RESET: assert property (
      (s.st == ST_KEY && cmd_v && !key_hit)
      |=> (s.st == ST_HOLD && s.step == 2'h0))
      else $error("guard key step did not reset on mismatch");

   AST_ENTRY_VIA_KEY: assert property (
      (s.st == ST_IDLE) |=> (s.st inside {ST_IDLE, ST_KEY}))
      else $error("repair mode entered without guard key");

   AST_ARMED_NEEDS_KEY: assert property (
      (s.st == ST_ARMED && $past(s.st) != ST_ARMED)
      |-> ($past(s.st) == ST_KEY && $past(s.step) == 2'h3))
      else $error("armed without all four key steps");

   AST_HOLD_NO_REPAIR: assert property (
      (s.st == ST_HOLD) |=> (s.st inside {ST_HOLD, ST_IDLE}))
      else $error("repair resumed after broken entry");

   AST_FUSE_STICKY: assert property (
      ($past(s.fused) & ~s.fused) == '0)
      else $error("programmed repair was undone");

   AST_ONE_PER_GROUP: assert property (
      (s.fused != $past(s.fused))
      |-> ($past(s.st) == ST_PROG && $onehot(s.fused ^ $past(s.fused))
           && ($past(s.fused) & (s.fused ^ $past(s.fused))) == '0))
      else $error("second repair in one bank group");

   AST_PATTERN_CANCEL: assert property (
      (s.st == ST_LAT && last_beat && !(s.all_low && low_now))
      |=> (s.st == ST_HOLD))
      else $error("repair began without four low beats");

   AST_SETTLE_LENGTH: assert property (
      ($past(s.st) == ST_SETTLE && s.st != ST_SETTLE)
      |-> ($past(s.tmr) == 32'(SETTLE_CYCLES - 1) && !REPAIR_BUSY))
      else $error("settle ended early");

   AST_REF_PAIR: assert property (
      (REF_STROBE && REF_SKIP_MASK != '0)
      |-> ($countones(REF_SKIP_MASK) == 2 && $past(s.ap)
           && (REF_SKIP_MASK & (REF_SKIP_MASK >> 1) & 8'h55) != '0))
      else $error("refresh skip mask not one bank pair");

   AST_BUS_ANSWER: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered in one cycle");

   CVR_REPAIR_DONE: cover property ($rose(|s.fused));
   CVR_KEY_BROKEN: cover property (s.st == ST_KEY ##1 s.st == ST_HOLD);
   CVR_CANCEL: cover property (s.st == ST_LAT ##1 s.st == ST_HOLD);
   CVR_SETTLED: cover property (s.st == ST_SETTLE ##1 s.st == ST_IDLE);
endmodule : hrrs_top
